// ---- logic/imc_consts.svh ----
// Constants of the two-wire bus master controller: offsets, bit positions, resets.
// Assumes inclusion by the controller module and the testbench only.
// Summary of operation
// - Master makes every SCL pulse and every Start and Stop condition.
// - Repeated Start ends a transfer and keeps the bus owned.
// - Transmit sends address byte with direction zero, eight-bit bytes, ack received.
// - Receive takes eight-bit bytes after an address byte with direction one.
// - Writing the transmit buffer with the master idle sets the full flag and starts shifting.
// - Each sent bit appears on SDA after SCL falls.
// - Status bit 14 reads one while a transmission runs.
// - Receive request bit 3 starts reception, ignored unless master idle.
// - Each baud rollover outside Start, Restart and Stop toggles SCL; SDA sampled on each SCL rise in receive and at the transmit ack bit.
// - Baud generator loads the reload value, counts to zero, then stops.
// - Released SCL suspends the generator until SCL reads high, then reloads.
// - Released SDA read low while SCL high, except in receive and at the transmit ack bit, flags collision, event, idle.
// - Collision in transmit clears full flag and releases both lines.
// - Collision in a condition sequence aborts it and clears its request bit.
// - After collision, an observed Stop raises the master event.
// - A transmit write after collision restarts from the new first bit.
// - Sleep abandons any transfer under way.
// - In CPU Idle the block runs unless the idle-stop bit is one.
// - On request the master sends an acknowledge after a received byte.
// - Completion of any master sequence raises the master event.
`ifndef IMC_CONSTS_SVH
`define IMC_CONSTS_SVH
`define IMC_IDX_RCV  10'h200
`define IMC_IDX_TRN  10'h202
`define IMC_IDX_BRG  10'h204
`define IMC_IDX_CON  10'h206
`define IMC_IDX_STAT 10'h208
`define IMC_IDX_ADD  10'h20A
`define IMC_TRN_RST  16'h00FF
`define IMC_CON_RST  16'h1000
`define IMC_CON_EN    15
`define IMC_CON_SIDL  13
`define IMC_CON_ACK_LEVEL_BIT 5
`define IMC_CON_ACK_REQUEST_BIT 4
`define IMC_CON_RECEIVE_REQUEST_BIT  3
`define IMC_CON_PEN   2
`define IMC_CON_RESTART_REQUEST_BIT  1
`define IMC_CON_SEN   0
`define IMC_ST_ACK    15
`define IMC_ST_TRS    14
`define IMC_ST_BCL    10
`define IMC_ST_IWCOL  7
`define IMC_ST_P      4
`define IMC_ST_S      3
`define IMC_ST_RBF    1
`define IMC_ST_TBF    0
`define IMC_TX_LAST   4'h8
`define IMC_RX_LAST   4'h7
`endif

// ---- logic/imc_pkg.sv ----
// Types shared by the bus master controller modules.
// Assumes the constants header is compiled alongside.
package imc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_RESTART, ST_STOP, ST_TX, ST_RX, ST_ACK
  } imc_state_t;
  typedef struct packed {
    logic scl_low;
    logic sda_low;
    logic last;
  } imc_lines_t;
  typedef struct packed {
    logic scl;
    logic sda;
  } imc_bus_t;
endpackage : imc_pkg

// ---- logic/imc_sync.sv ----
// Two-stage synchroniser for the bus lines.
// Assumes asynchronous pin levels and a free-running clock.
`timescale 1ns/1ps
module imc_sync (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Lines
  input  wire logic [1:0] d,
  output logic      [1:0] q
);
  logic [1:0] meta_q;
  // Idle bus level is high, so reset to ones
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 2'h3;
      q      <= 2'h3;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : imc_sync

// ---- logic/imc_baud_gen.sv ----
// Reload and count-down baud generator.
// Assumes the reload value is at least two.
`timescale 1ns/1ps
module imc_baud_gen (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Control
  input  wire logic        load,
  input  wire logic        run,
  input  wire logic [15:0] reload,
  // Status
  output logic             zero
);
  logic [15:0] cnt_q;
  // Counts down and rests at zero until loaded again
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
    end else if (load) begin
      cnt_q <= reload;
    end else if (run && cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end
  assign zero = (cnt_q == 16'h0000);
endmodule : imc_baud_gen

// ---- logic/imc_master.sv ----
// Two-wire bus master controller with an APB register slave.
// Assumes open-drain pads outside; oe high pulls the line low.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "imc_consts.svh"
module imc_master import imc_pkg::*; (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             scl_out,
  output logic             scl_oe,
  output logic             sda_out,
  output logic             sda_oe,
  // Power and events
  input  wire logic        sleep_req,
  input  wire logic        cpu_idle,
  output logic             master_event
);
  imc_state_t  state_q, go;
  imc_lines_t  lv;
  imc_bus_t    bus_s, prev_q;
  logic [1:0]  sync_q, step_q;
  logic [3:0]  bit_q;
  logic [7:0]  sh_q, rcv_q;
  logic [15:0] con_q, trn_q, brg_q, add_q, stat_w;
  logic [4:0]  req_q, go_req;
  logic        armed_q, scl_low_q, sda_low_q, watch_q, mev_q, pready_q;
  logic        pslverr_q, pin_q, ackstat_q, bcl_q, iwcol_q, p_q, s_q, rbf_q, tbf_q;
  logic [31:0] prdata_q;
  logic        acc, wr, rd, wr_con, wr_trn, mapped, run, abort, busy, idle;
  logic        brg_zero, brg_load, adv, coll, done_all, next_bit, rise_smp;
  logic        expect_hi, start_det, stop_det, lv_scl_low, sda_s;

  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    hit = (a[11:2] == idx) && (a[1:0] == 2'h0);
  endfunction : hit

  // Line levels of each step of each sequence
  function automatic imc_lines_t levels(input imc_state_t st, input logic [1:0] s,
                                        input logic [3:0] b, input logic msb,
                                        input logic ack_level_bit);
    levels = '0;
    case (st)
      ST_START: begin
        levels.scl_low = (s == 2'h1);
        levels.sda_low = 1'b1;
        levels.last    = (s == 2'h1);
      end
      ST_RESTART: begin
        levels.scl_low = (s == 2'h0) || (s == 2'h3);
        levels.sda_low = (s >= 2'h2);
        levels.last    = (s == 2'h3);
      end
      ST_STOP: begin
        levels.scl_low = (s == 2'h0);
        levels.sda_low = (s != 2'h2);
        levels.last    = (s == 2'h2);
      end
      ST_ACK: begin
        levels.scl_low = (s == 2'h0);
        levels.sda_low = ~ack_level_bit;
        levels.last    = (s == 2'h1);
      end
      ST_TX: begin
        levels.scl_low = (s == 2'h0);
        levels.sda_low = (b != `IMC_TX_LAST) && !msb;
        levels.last    = (s == 2'h1);
      end
      ST_RX: begin
        levels.scl_low = (s == 2'h0);
        levels.sda_low = 1'b0;
        levels.last    = (s == 2'h1);
      end
      default: levels = '0;
    endcase
  endfunction : levels

  imc_sync u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({scl_in, sda_in}),
    .q     (sync_q)
  );
  assign bus_s = imc_bus_t'(sync_q);
  assign sda_s = bus_s.sda;

  imc_baud_gen u_brg (
    .clk    (pclk),
    .rst_n  (presetn),
    .load   (brg_load),
    .run    (run),
    .reload (brg_q),
    .zero   (brg_zero)
  );

  // Access completes on the second access-phase edge
  assign acc    = psel && penable && pready_q;
  assign wr     = acc && pwrite;
  assign rd     = acc && !pwrite;
  assign wr_con = wr && hit(paddr, `IMC_IDX_CON);
  assign wr_trn = wr && hit(paddr, `IMC_IDX_TRN);
  assign mapped = hit(paddr, `IMC_IDX_RCV) || hit(paddr, `IMC_IDX_TRN) ||
                  hit(paddr, `IMC_IDX_BRG) || hit(paddr, `IMC_IDX_CON) ||
                  hit(paddr, `IMC_IDX_STAT) || hit(paddr, `IMC_IDX_ADD);

  // Sleep or disable abandons work; idle-stop only freezes it
  assign abort = sleep_req || !con_q[`IMC_CON_EN];
  assign run   = !abort && !(cpu_idle && con_q[`IMC_CON_SIDL]);
  assign idle  = (state_q == ST_IDLE);
  assign busy  = !idle;
  assign lv    = levels(state_q, step_q, bit_q, sh_q[7], con_q[`IMC_CON_ACK_LEVEL_BIT]);
  assign lv_scl_low = lv.scl_low;

  // Released SCL loads the generator only once seen high
  assign brg_load = busy && run && !armed_q &&
                    (lv.scl_low || (!scl_low_q && bus_s.scl));
  assign rise_smp = brg_load && !lv.scl_low;
  assign adv      = busy && run && armed_q && brg_zero;
  assign expect_hi = !lv.sda_low && (state_q != ST_RX) &&
                     !((state_q == ST_TX) && (bit_q == `IMC_TX_LAST));
  assign coll     = adv && !lv.scl_low && expect_hi && bus_s.scl && !bus_s.sda;
  assign done_all = adv && lv.last && !coll &&
                    (((state_q != ST_TX) && (state_q != ST_RX)) ||
                     ((state_q == ST_TX) && (bit_q == `IMC_TX_LAST)) ||
                     ((state_q == ST_RX) && (bit_q == `IMC_RX_LAST)));
  assign next_bit = adv && lv.last && !coll && !done_all;

  // Request decode, one operation at a time
  always_comb begin
    go     = ST_IDLE;
    go_req = 5'h00;
    if (idle && run) begin
      if (wr_con && pwdata[`IMC_CON_SEN]) begin
        go = ST_START;
        go_req[`IMC_CON_SEN] = 1'b1;
      end else if (wr_con && pwdata[`IMC_CON_RESTART_REQUEST_BIT]) begin
        go = ST_RESTART;
        go_req[`IMC_CON_RESTART_REQUEST_BIT] = 1'b1;
      end else if (wr_con && pwdata[`IMC_CON_PEN]) begin
        go = ST_STOP;
        go_req[`IMC_CON_PEN] = 1'b1;
      end else if (wr_con && pwdata[`IMC_CON_RECEIVE_REQUEST_BIT]) begin
        go = ST_RX;
        go_req[`IMC_CON_RECEIVE_REQUEST_BIT] = 1'b1;
      end else if (wr_con && pwdata[`IMC_CON_ACK_REQUEST_BIT]) begin
        go = ST_ACK;
        go_req[`IMC_CON_ACK_REQUEST_BIT] = 1'b1;
      end else if (wr_trn) begin
        go = ST_TX;
      end
    end
  end

  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      step_q  <= 2'h0;
      bit_q   <= 4'h0;
      armed_q <= 1'b0;
    end else if (abort || coll) begin
      state_q <= ST_IDLE;
      armed_q <= 1'b0;
    end else if (go != ST_IDLE) begin
      state_q <= go;
      step_q  <= 2'h0;
      bit_q   <= 4'h0;
      armed_q <= 1'b0;
    end else if (adv) begin
      armed_q <= 1'b0;
      if (done_all) begin
        state_q <= ST_IDLE;
      end else if (next_bit) begin
        step_q <= 2'h0;
        bit_q  <= bit_q + 4'h1;
      end else begin
        step_q <= step_q + 2'h1;
      end
    end else if (brg_load) begin
      armed_q <= 1'b1;
    end
  end

  // Line drive; data changes only with SCL pulled low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (abort || coll) begin
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (done_all) begin
      scl_low_q <= (state_q != ST_STOP);
      sda_low_q <= (state_q == ST_START) || (state_q == ST_RESTART);
    end else if (busy && run) begin
      scl_low_q <= lv.scl_low;
      // Data waits a cycle after SCL is pulled low, never moving with the fall
      sda_low_q <= (lv.scl_low && !scl_low_q) ? sda_low_q : lv.sda_low;
    end
  end

  // Shift register and receive buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q      <= 8'h00;
      rcv_q     <= 8'h00;
      ackstat_q <= 1'b0;
    end else begin
      if (go == ST_TX) begin
        sh_q <= pwdata[7:0];
      end else if (go == ST_RX) begin
        sh_q <= 8'h00;
      end else if (state_q == ST_TX && next_bit) begin
        sh_q <= {sh_q[6:0], 1'b0};
      end else if (state_q == ST_RX && rise_smp) begin
        sh_q <= {sh_q[6:0], bus_s.sda};
      end
      if (state_q == ST_TX && rise_smp && bit_q == `IMC_TX_LAST) begin
        ackstat_q <= bus_s.sda;
      end
      if (state_q == ST_RX && done_all) begin
        rcv_q <= sh_q;
      end
    end
  end

  // Software registers; hardware sets win over clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      con_q <= `IMC_CON_RST;
      trn_q <= `IMC_TRN_RST;
      brg_q <= 16'h0000;
      add_q <= 16'h0000;
      req_q <= 5'h00;
    end else begin
      if (wr_con) begin
        con_q <= pwdata[15:0];
      end
      if (go == ST_TX) begin
        trn_q <= pwdata[15:0];
      end
      if (wr && hit(paddr, `IMC_IDX_BRG)) begin
        brg_q <= pwdata[15:0];
      end
      if (wr && hit(paddr, `IMC_IDX_ADD)) begin
        add_q <= pwdata[15:0];
      end
      if (go != ST_IDLE) begin
        req_q <= go_req;
      end else if (done_all || coll || abort) begin
        req_q <= 5'h00;
      end
    end
  end

  // Status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbf_q   <= 1'b0;
      bcl_q   <= 1'b0;
      iwcol_q <= 1'b0;
      rbf_q   <= 1'b0;
    end else begin
      if (go == ST_TX) begin
        tbf_q <= 1'b1;
      end else if ((state_q == ST_TX && done_all) || coll || abort) begin
        tbf_q <= 1'b0;
      end
      if (coll) begin
        bcl_q <= 1'b1;
      end else if (wr && hit(paddr, `IMC_IDX_STAT) && !pwdata[`IMC_ST_BCL]) begin
        bcl_q <= 1'b0;
      end
      if (wr_trn && busy) begin
        iwcol_q <= 1'b1;
      end else if (wr && hit(paddr, `IMC_IDX_STAT) && !pwdata[`IMC_ST_IWCOL]) begin
        iwcol_q <= 1'b0;
      end
      if (state_q == ST_RX && done_all) begin
        rbf_q <= 1'b1;
      end else if (rd && hit(paddr, `IMC_IDX_RCV)) begin
        rbf_q <= 1'b0;
      end
    end
  end

  // Bus watcher for Start, Stop and post-collision wait
  assign start_det = prev_q.sda && !bus_s.sda && prev_q.scl && bus_s.scl;
  assign stop_det  = !prev_q.sda && bus_s.sda && prev_q.scl && bus_s.scl;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q  <= '1;
      s_q     <= 1'b0;
      p_q     <= 1'b0;
      watch_q <= 1'b0;
      mev_q   <= 1'b0;
    end else begin
      prev_q <= bus_s;
      if (start_det) begin
        s_q <= 1'b1;
        p_q <= 1'b0;
      end else if (stop_det) begin
        s_q <= 1'b0;
        p_q <= 1'b1;
      end
      if (coll) begin
        watch_q <= 1'b1;
      end else if (stop_det) begin
        watch_q <= 1'b0;
      end
      mev_q <= done_all || coll || (watch_q && stop_det);
    end
  end

  always_comb begin
    stat_w = 16'h0000;
    stat_w[`IMC_ST_ACK]   = ackstat_q;
    stat_w[`IMC_ST_TRS]   = (state_q == ST_TX);
    stat_w[`IMC_ST_BCL]   = bcl_q;
    stat_w[`IMC_ST_IWCOL] = iwcol_q;
    stat_w[`IMC_ST_P]     = p_q;
    stat_w[`IMC_ST_S]     = s_q;
    stat_w[`IMC_ST_RBF]   = rbf_q;
    stat_w[`IMC_ST_TBF]   = tbf_q;
  end

  // APB answer, one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      pin_q     <= 1'b0;
    end else begin
      pready_q  <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !mapped;
      pin_q     <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      if (psel && penable && !pready_q && !pwrite) begin
        if (hit(paddr, `IMC_IDX_RCV)) prdata_q <= {24'h000000, rcv_q};
        if (hit(paddr, `IMC_IDX_TRN)) prdata_q <= {16'h0000, trn_q};
        if (hit(paddr, `IMC_IDX_BRG)) prdata_q <= {16'h0000, brg_q};
        if (hit(paddr, `IMC_IDX_CON)) prdata_q <= {16'h0000, con_q[15:5], req_q};
        if (hit(paddr, `IMC_IDX_STAT)) prdata_q <= {16'h0000, stat_w};
        if (hit(paddr, `IMC_IDX_ADD)) prdata_q <= {16'h0000, add_q};
      end
    end
  end

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign scl_out      = pin_q;
  assign sda_out      = pin_q;
  assign scl_oe       = scl_low_q;
  assign sda_oe       = sda_low_q;
  assign master_event = mev_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_transmit_in_progress_bit_tracks: assert property ((state_q == ST_TX) == stat_w[`IMC_ST_TRS])
    else $error("transmit status bit does not follow transmission");
  a_write_starts_tx: assert property (go == ST_TX |=> tbf_q && state_q == ST_TX)
    else $error("transmit write did not start shifting");
  a_receive_request_bit_ignored: assert property ((wr_con && pwdata[`IMC_CON_RECEIVE_REQUEST_BIT] && busy && !adv &&
      !coll && !abort) |=> state_q == $past(state_q))
    else $error("receive request taken while busy");
  a_coll_release: assert property (coll |=> !scl_oe && !sda_oe && idle && !tbf_q &&
      req_q == 5'h00 && bcl_q)
    else $error("collision did not release the bus");
  a_coll_event: assert property (coll |=> master_event ##1 !master_event)
    else $error("collision event not a single pulse");
  a_brg_waits_high: assert property ($rose(armed_q) && !$past(lv_scl_low) |->
      $past(bus_s.scl))
    else $error("generator resumed before SCL high");
  a_tx_data_low: assert property ((state_q == ST_TX) && $changed(sda_oe) |->
      scl_oe && $past(scl_oe))
    else $error("SDA changed while SCL released");
  a_rx_sample: assert property ((state_q == ST_RX) && rise_smp |=> sh_q[0] == $past(sda_s))
    else $error("receive bit not sampled at SCL rise");
  a_stop_watch: assert property (watch_q && stop_det |=> master_event && !watch_q)
    else $error("stop after collision gave no event");
  a_req_clear: assert property (done_all |=> req_q == 5'h00 && master_event)
    else $error("request bit not cleared on completion");
  a_idle_halt: assert property (cpu_idle && con_q[`IMC_CON_SIDL] && !abort |=>
      $stable(step_q) && $stable(bit_q))
    else $error("sequencer moved while halted");
  a_sleep_abort: assert property (sleep_req |=> idle && !scl_oe && !sda_oe)
    else $error("sleep did not abandon transfer");
endmodule : imc_master

// ---- tb/imc_slave.sv ----
// Behavioural slave on the two-wire bus, with a stand-in for a rival master.
// Assumes open-drain wires with pull-ups resolved by the bench.
`timescale 1ns/1ps
module imc_slave (
  // Bus wires
  input  wire logic       scl,
  input  wire logic       sda,
  // Scenario controls
  input  wire logic       grab,
  input  wire logic       slow,
  input  wire logic [7:0] rd_byte,
  // Pull-downs and capture
  output logic            scl_low,
  output logic            sda_low,
  output logic      [7:0] rx_byte,
  output logic      [7:0] n_rx
);
  logic [3:0] bit_n;
  logic       act, adr, rd, ack;
  logic [7:0] sh, tx;
  initial begin
    {act, adr, rd, ack, scl_low} = '0;
    bit_n = 4'h0;
    {sh, tx, rx_byte, n_rx} = '0;
  end
  // Start or restart opens an address phase
  always @(negedge sda) if (scl) begin
    act = 1'b1;
    adr = 1'b1;
    rd = 1'b0;
    // The SCL fall that closes the Start wraps the count to zero
    bit_n = 4'hF;
  end
  always @(posedge sda) if (scl) act = 1'b0;
  // Master's acknowledge is captured as a byte; a high level ends the read
  always @(posedge scl) if (act) begin
    if (bit_n < 4'h8) sh = {sh[6:0], sda};
    else if (rd && !adr) begin
      rx_byte = {7'h00, sda};
      n_rx = n_rx + 8'h01;
      act = !sda;
    end
  end
  always @(negedge scl) if (act) begin
    bit_n = bit_n + 4'h1;
    if (bit_n == 4'h8 && (adr || !rd)) begin
      rx_byte = sh;
      n_rx = n_rx + 8'h01;
      ack = 1'b1;
    end else if (bit_n == 4'h9) begin
      bit_n = 4'h0;
      ack = 1'b0;
      tx = rd_byte;
      if (adr) rd = sh[0];
      adr = 1'b0;
    end
  end
  // Slow mode stretches every low phase, so SCL high comes late
  always @(negedge scl) if (slow) begin
    scl_low = 1'b1;
    #300 scl_low = 1'b0;
  end
  // Data changes only while SCL is low, right after its fall
  assign sda_low = grab | ack | (act && rd && !adr && bit_n < 4'h8 && !tx[3'(7 - bit_n)]);
endmodule : imc_slave

// ---- tb/imc_master_test.sv ----
// Self-checking bench of the bus master controller over APB.
// Assumes the design files and the slave model are compiled first.
`timescale 1ns/1ps
`include "imc_consts.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module imc_master_test;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} imc_exp_t;
  localparam logic [11:0] A_RCV = {`IMC_IDX_RCV, 2'b00};
  localparam logic [11:0] A_TRN = {`IMC_IDX_TRN, 2'b00};
  localparam logic [11:0] A_CON = {`IMC_IDX_CON, 2'b00};
  localparam logic [11:0] A_ST  = {`IMC_IDX_STAT, 2'b00};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        scl_out, scl_oe, sda_out, sda_oe, sleep_req, cpu_idle, master_event;
  logic        scl_w, sda_w, s_scl, s_sda, grab, slow;
  logic [7:0]  rd_byte, rx_byte, n_rx, v, b;
  logic [15:0] seed = 16'hCCC8;
  int          err_total = 0, comparisons = 0, cyc = 0;
  imc_exp_t    exp_q[$], x;
  logic [7:0]  byte_q[$];
  logic [15:0] rst_v[6] = '{16'h0000, `IMC_TRN_RST, 16'h0000, `IMC_CON_RST, 16'h0000, 16'h0000};
  assign scl_w = ~(scl_oe | s_scl);
  assign sda_w = ~(sda_oe | s_sda);
  imc_master uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl_w), .sda_in(sda_w), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_out(sda_out), .sda_oe(sda_oe), .sleep_req(sleep_req), .cpu_idle(cpu_idle),
    .master_event(master_event));
  imc_slave peer (.scl(scl_w), .sda(sda_w), .grab(grab), .slow(slow), .rd_byte(rd_byte),
    .scl_low(s_scl), .sda_low(s_sda), .rx_byte(rx_byte), .n_rx(n_rx));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task automatic rnd(output logic [7:0] r);
    seed = lfsr_next(seed);
    r = seed[7:0];
  endtask : rnd
  task automatic stop_test();
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  // Request held from setup until the edge that samples pready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic e);
    exp_q.push_back('{d, m, e});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
    apb(1'b0, a, d, m, 1'b0);
  endtask : rd
  // Event pulse lasts one cycle, so it is sampled at every falling edge
  task automatic wait_evt();
    int n;
    n = 0;
    @(negedge pclk);
    while (master_event !== 1'b1 && n < 3000) begin
      @(negedge pclk);
      n++;
    end
    `CHK(master_event, 1'b1)
  endtask : wait_evt
  always @(posedge pclk) if (psel && penable && pready === 1'b1) begin
    x = exp_q.pop_front();
    `CHK({pslverr, prdata & x.m}, {x.e, x.d & x.m})
  end
  always @(n_rx) if (n_rx != 8'h00) begin
    b = byte_q.pop_front();
    `CHK(rx_byte, b)
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, sleep_req, cpu_idle, grab, slow} = '0;
    {paddr, pwdata, rd_byte} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd({10'h200 + 10'(2 * i), 2'b00}, {16'h0, rst_v[i]}, '1);
    apb(1'b0, 12'h830, 32'h0, '1, 1'b1);
    wr({`IMC_IDX_BRG, 2'b00}, 32'h3);
    wr(A_CON, 32'h8000);
    cpu_idle <= 1'b1;
    wr(A_CON, 32'h8001);
    wait_evt();
    rd(A_CON, 32'h8000, '1);
    rnd(v);
    byte_q.push_back({v[6:0], 1'b0});
    wr(A_TRN, {v[6:0], 1'b0});
    rd(A_ST, 32'h4001, 32'h4001);
    wr(A_CON, 32'h8008);
    wait_evt();
    rd(A_CON, 32'h8000, '1);
    rd(A_ST, 32'h0, 32'hC001);
    cpu_idle <= 1'b0;
    slow <= 1'b1;
    rnd(v);
    byte_q.push_back(v);
    wr(A_TRN, v);
    wait_evt();
    slow <= 1'b0;
    wr(A_CON, 32'h8002);
    wait_evt();
    rd(A_CON, 32'h8000, '1);
    rnd(v);
    rd_byte <= v;
    byte_q.push_back({v[6:0], 1'b1});
    wr(A_TRN, {v[6:0], 1'b1});
    wait_evt();
    wr(A_CON, 32'h8008);
    wait_evt();
    rd(A_RCV, {24'h0, v}, '1);
    byte_q.push_back(8'h01);
    wr(A_CON, 32'h8030);
    wait_evt();
    rd(A_CON, 32'h8020, '1);
    wr(A_CON, 32'h8004);
    wait_evt();
    `CHK({scl_w, sda_w}, 2'b11)
    wr(A_CON, 32'h8001);
    wait_evt();
    grab <= 1'b1;
    wr(A_TRN, 32'hFF);
    wait_evt();
    rd(A_ST, 32'h0400, 32'h4401);
    rd(A_CON, 32'h8000, '1);
    grab <= 1'b0;
    wait_evt();
    wr(A_ST, 32'h0);
    wr(A_CON, 32'h8001);
    wait_evt();
    rnd(v);
    byte_q.push_back(v);
    wr(A_TRN, v);
    wait_evt();
    grab <= 1'b1;
    wr(A_CON, 32'h8004);
    wait_evt();
    rd(A_CON, 32'h8000, '1);
    rd(A_ST, 32'h0400, 32'h0400);
    grab <= 1'b0;
    wait_evt();
    rnd(v);
    wr(A_TRN, v);
    cpu_idle <= 1'b1;
    wr(A_CON, 32'hA000);
    repeat (200) @(posedge pclk);
    rd(A_ST, 32'h4001, 32'h4001);
    sleep_req <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK({scl_oe, sda_oe}, 2'b00)
    stop_test();
  end
endmodule : imc_master_test
